/* logic/cpspc_map.svh */
// constants for the processing-state controller.
// assumes a single 20 MHz clock and an active-low asynchronous reset.
`ifndef CPSPC_MAP_SVH
`define CPSPC_MAP_SVH
`define CPSPC_VEC_POR_PC 32'h0000_0000
`define CPSPC_VEC_POR_SP 32'h0000_0004
`define CPSPC_VEC_MAN_PC 32'h0000_0008
`define CPSPC_VEC_MAN_SP 32'h0000_000C
`define CPSPC_VEC_NMI 32'h0000_002C
`define CPSPC_VEC_DMAERR 32'h0000_0028
`define CPSPC_MASK_ALL 4'hF
`define CPSPC_OSC_STAB_NS 10000
`define CPSPC_CLK_NS 50
`define CPSPC_OSC_STAB_CYC ((`CPSPC_OSC_STAB_NS + `CPSPC_CLK_NS - 1) / `CPSPC_CLK_NS)
`endif

/* logic/cpspc_pkg.sv */
// types for the processing-state controller.
// assumes cpspc_map.svh supplies the numbers.
package cpspc_pkg;
   typedef enum logic [2:0] {
      ST_RESET = 3'h0,
      ST_EXCEPT = 3'h1,
      ST_BUSREL = 3'h2,
      ST_EXEC = 3'h3,
      ST_SLEEP = 3'h4,
      ST_STANDBY = 3'h5
   } cpspc_state_t;
   typedef enum logic [2:0] {
      EX_RST_PC = 3'h0,
      EX_RST_SP = 3'h1,
      EX_PUSH_PC = 3'h2,
      EX_PUSH_SR = 3'h3,
      EX_VEC = 3'h4,
      EX_DONE = 3'h5
   } cpspc_ex_t;
endpackage

/* logic/cpspc_ctrl.sv */
// processing-state controller: reset kind, exception entry steps,
// sleep/standby power-down and bus release.
// assumes the core performs each requested memory step in one cycle.
`timescale 1ns/1ps
`include "cpspc_map.svh"
module cpspc_ctrl (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic CHIP_INIT_PIN_N_IN,
   input wire logic NMI_IN,
   input wire logic IRQ_IN,
   input wire logic DMA_ADDR_ERR_IN,
   input wire logic HALT_EXEC_IN,
   input wire logic DEEP_HALT_SELECT_IN,
   input wire logic PIN_FLOAT_SELECT_IN,
   input wire logic BUS_REQ_IN,
   output logic [2:0] STATE_OUT,
   output logic BUS_GRANT_OUT,
   output logic CPU_RUN_OUT,
   output logic CPU_INIT_OUT,
   output logic PERIPH_INIT_OUT,
   output logic BUS_UNIT_INIT_OUT,
   output logic PERIPH_HALT_OUT,
   output logic OSC_STOP_OUT,
   output logic PIN_FLOAT_OUT,
   output logic MEM_REQ_OUT,
   output logic MEM_WRITE_OUT,
   output logic [31:0] MEM_ADDR_OUT,
   output logic VBR_CLEAR_OUT,
   output logic MASK_LOAD_OUT,
   output logic [3:0] IRQ_MASK_LEVEL_OUT
);
   localparam int STAB = `CPSPC_OSC_STAB_CYC;
   localparam logic [15:0] STAB_CNT = 16'(STAB);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic rst_s1_reg, rst_s2_reg;
   logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg;
   logic req_s1_reg, req_s2_reg;
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
         nmi_s1_reg <= 1'b1;
         nmi_s2_reg <= 1'b1;
         nmi_s3_reg <= 1'b1;
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= CHIP_INIT_PIN_N_IN;
         rst_s2_reg <= rst_s1_reg;
         nmi_s1_reg <= NMI_IN;
         nmi_s2_reg <= nmi_s1_reg;
         nmi_s3_reg <= nmi_s2_reg;
         req_s1_reg <= BUS_REQ_IN;
         req_s2_reg <= req_s1_reg;
      end
   end
   // nmi starts high: a low start would read as a manual reset and a false rise
   wire logic pin_rst_n = rst_s2_reg;
   wire logic nmi_lvl = nmi_s2_reg;
   wire logic nmi_prev = nmi_s3_reg;
   wire logic bus_req = req_s2_reg;
   wire logic nmi_rise = nmi_lvl && !nmi_prev;

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   cpspc_pkg::cpspc_state_t state_reg, state_next;
   cpspc_pkg::cpspc_ex_t ex_reg, ex_next;
   logic manual_reg;
   logic is_reset_ex_reg;
   logic [31:0] vec_reg;
   logic [15:0] stab_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         cpspc_pkg::ST_RESET: begin
            if (pin_rst_n)
               state_next = cpspc_pkg::ST_EXCEPT;
         end
         cpspc_pkg::ST_EXCEPT: begin
            if (ex_reg == cpspc_pkg::EX_DONE)
               state_next = cpspc_pkg::ST_EXEC;
         end
         cpspc_pkg::ST_EXEC: begin
            if (bus_req)
               state_next = cpspc_pkg::ST_BUSREL;
            else if (IRQ_IN || nmi_rise || DMA_ADDR_ERR_IN)
               state_next = cpspc_pkg::ST_EXCEPT;
            else if (HALT_EXEC_IN && !DEEP_HALT_SELECT_IN)
               state_next = cpspc_pkg::ST_SLEEP;
            else if (HALT_EXEC_IN && DEEP_HALT_SELECT_IN)
               state_next = cpspc_pkg::ST_STANDBY;
         end
         cpspc_pkg::ST_BUSREL: begin
            if (!bus_req)
               state_next = cpspc_pkg::ST_EXEC;
         end
         cpspc_pkg::ST_SLEEP: begin
            if (IRQ_IN || nmi_rise || DMA_ADDR_ERR_IN)
               state_next = cpspc_pkg::ST_EXCEPT;
         end
         cpspc_pkg::ST_STANDBY: begin
            if (stab_reg == 16'h0001)
               state_next = cpspc_pkg::ST_EXCEPT;
         end
         default: state_next = cpspc_pkg::ST_RESET;
      endcase
      if (!pin_rst_n)
         state_next = cpspc_pkg::ST_RESET;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         state_reg <= cpspc_pkg::ST_RESET;
      else
         state_reg <= state_next;
   end

   // reset kind is latched from nmi while the reset pin is low
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         manual_reg <= 1'b0;
      else if (!pin_rst_n)
         manual_reg <= !nmi_lvl;
   end

   // stabilisation counter; started by the nmi that wakes standby
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         stab_reg <= 16'h0000;
      else if (state_reg == cpspc_pkg::ST_STANDBY && stab_reg == 16'h0000 && nmi_rise)
         stab_reg <= STAB_CNT;
      else if (state_reg != cpspc_pkg::ST_STANDBY)
         stab_reg <= 16'h0000;
      else if (stab_reg != 16'h0000)
         stab_reg <= stab_reg - 16'h0001;
   end

   // ----------------------------------------------------------------
   // exception step sequencer
   // ----------------------------------------------------------------
   always_comb begin
      ex_next = ex_reg;
      unique case (ex_reg)
         cpspc_pkg::EX_RST_PC: ex_next = cpspc_pkg::EX_RST_SP;
         cpspc_pkg::EX_RST_SP: ex_next = cpspc_pkg::EX_DONE;
         cpspc_pkg::EX_PUSH_PC: ex_next = cpspc_pkg::EX_PUSH_SR;
         cpspc_pkg::EX_PUSH_SR: ex_next = cpspc_pkg::EX_VEC;
         cpspc_pkg::EX_VEC: ex_next = cpspc_pkg::EX_DONE;
         cpspc_pkg::EX_DONE: ex_next = cpspc_pkg::EX_DONE;
         default: ex_next = cpspc_pkg::EX_DONE;
      endcase
      if (state_reg != cpspc_pkg::ST_EXCEPT)
         ex_next = (state_next == cpspc_pkg::ST_EXCEPT && state_reg != cpspc_pkg::ST_RESET)
            ? cpspc_pkg::EX_PUSH_PC : cpspc_pkg::EX_RST_PC;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         ex_reg <= cpspc_pkg::EX_RST_PC;
      else
         ex_reg <= ex_next;
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         is_reset_ex_reg <= 1'b1;
      else if (state_reg != cpspc_pkg::ST_EXCEPT)
         is_reset_ex_reg <= (state_reg == cpspc_pkg::ST_RESET);
   end

   // vector chosen at exception entry; dma error outranks irq and nmi
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN)
         vec_reg <= `CPSPC_VEC_POR_PC;
      else if (state_reg != cpspc_pkg::ST_EXCEPT) begin
         if (DMA_ADDR_ERR_IN)
            vec_reg <= `CPSPC_VEC_DMAERR;
         else
            vec_reg <= `CPSPC_VEC_NMI;
      end
   end

   // ----------------------------------------------------------------
   // memory step outputs
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         MEM_REQ_OUT <= 1'b0;
         MEM_WRITE_OUT <= 1'b0;
         MEM_ADDR_OUT <= 32'h0000_0000;
      end else begin
         MEM_REQ_OUT <= (state_next == cpspc_pkg::ST_EXCEPT) && (ex_next != cpspc_pkg::EX_DONE);
         MEM_WRITE_OUT <= (ex_next == cpspc_pkg::EX_PUSH_PC) ||
            (ex_next == cpspc_pkg::EX_PUSH_SR);
         unique case (ex_next)
            cpspc_pkg::EX_RST_PC:
               MEM_ADDR_OUT <= manual_reg ? `CPSPC_VEC_MAN_PC : `CPSPC_VEC_POR_PC;
            cpspc_pkg::EX_RST_SP:
               MEM_ADDR_OUT <= manual_reg ? `CPSPC_VEC_MAN_SP : `CPSPC_VEC_POR_SP;
            cpspc_pkg::EX_VEC: MEM_ADDR_OUT <= vec_reg;
            default: MEM_ADDR_OUT <= 32'h0000_0000;
         endcase
      end
   end

   // mask and vector base are loaded once, at the end of reset processing
   wire logic rst_done = is_reset_ex_reg && ex_reg == cpspc_pkg::EX_RST_SP;
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         VBR_CLEAR_OUT <= 1'b0;
         MASK_LOAD_OUT <= 1'b0;
         IRQ_MASK_LEVEL_OUT <= 4'h0;
      end else begin
         VBR_CLEAR_OUT <= rst_done;
         MASK_LOAD_OUT <= rst_done;
         if (state_reg == cpspc_pkg::ST_RESET)
            IRQ_MASK_LEVEL_OUT <= 4'h0;
         else if (rst_done)
            IRQ_MASK_LEVEL_OUT <= `CPSPC_MASK_ALL;
      end
   end

   // ----------------------------------------------------------------
   // power and init outputs
   // ----------------------------------------------------------------
   wire logic in_rst = (state_reg == cpspc_pkg::ST_RESET);
   wire logic in_sby = (state_reg == cpspc_pkg::ST_STANDBY);
   assign STATE_OUT = state_reg;
   assign BUS_GRANT_OUT = (state_reg == cpspc_pkg::ST_BUSREL);
   assign CPU_RUN_OUT = (state_reg == cpspc_pkg::ST_EXEC);
   assign CPU_INIT_OUT = in_rst;
   assign PERIPH_INIT_OUT = in_rst || in_sby;
   // bus unit left alone on manual reset so refresh goes on
   assign BUS_UNIT_INIT_OUT = in_rst && !manual_reg;
   // peripherals only halt in standby, sleep leaves them running
   assign PERIPH_HALT_OUT = in_sby;
   assign OSC_STOP_OUT = in_sby && stab_reg == 16'h0000;
   assign PIN_FLOAT_OUT = in_sby && PIN_FLOAT_SELECT_IN;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   pin_reset_a: assert property (!pin_rst_n |=> state_reg == cpspc_pkg::ST_RESET)
      else $error("reset pin low did not reach reset state");
   sleep_entry_a: assert property (state_reg == cpspc_pkg::ST_EXEC && HALT_EXEC_IN
      && !DEEP_HALT_SELECT_IN && !bus_req && !IRQ_IN && !nmi_rise && !DMA_ADDR_ERR_IN
      && pin_rst_n |=> state_reg == cpspc_pkg::ST_SLEEP)
      else $error("halt with select clear did not sleep");
   standby_entry_a: assert property (state_reg == cpspc_pkg::ST_EXEC && HALT_EXEC_IN
      && DEEP_HALT_SELECT_IN && !bus_req && !IRQ_IN && !nmi_rise && !DMA_ADDR_ERR_IN
      && pin_rst_n |=> OSC_STOP_OUT)
      else $error("halt with select set did not stop oscillator");
   sleep_wake_a: assert property (state_reg == cpspc_pkg::ST_SLEEP && IRQ_IN
      && pin_rst_n |=> state_reg == cpspc_pkg::ST_EXCEPT ##[1:6] state_reg == cpspc_pkg::ST_EXEC)
      else $error("sleep wake skipped exception processing");
   standby_hold_a: assert property (state_reg == cpspc_pkg::ST_STANDBY && pin_rst_n
      && stab_reg > 16'h0001 |=> state_reg == cpspc_pkg::ST_STANDBY)
      else $error("standby left before stabilisation");
   nmi_wake_a: assert property (state_reg == cpspc_pkg::ST_STANDBY && stab_reg == 16'h0000
      && nmi_rise && pin_rst_n |=> !OSC_STOP_OUT && stab_reg == STAB_CNT)
      else $error("standby nmi did not start stabilisation");
   bus_grant_a: assert property (state_reg == cpspc_pkg::ST_EXEC && bus_req
      && pin_rst_n |=> BUS_GRANT_OUT)
      else $error("bus request not granted");
   bus_hold_a: assert property (state_reg == cpspc_pkg::ST_BUSREL && bus_req
      && pin_rst_n |=> state_reg == cpspc_pkg::ST_BUSREL)
      else $error("bus release left while request stands");
   reset_vec_a: assert property ($rose(pin_rst_n) && manual_reg
      |-> ##[1:3] MEM_REQ_OUT && MEM_ADDR_OUT == `CPSPC_VEC_MAN_PC)
      else $error("manual reset fetched wrong vector");
   mask_set_a: assert property (MASK_LOAD_OUT
      |-> IRQ_MASK_LEVEL_OUT == `CPSPC_MASK_ALL && VBR_CLEAR_OUT)
      else $error("reset did not set mask and clear base");
   mask_reset_a: assert property (in_rst |=> IRQ_MASK_LEVEL_OUT == 4'h0)
      else $error("reset did not clear mask level");
   push_first_a: assert property (state_reg == cpspc_pkg::ST_EXEC && IRQ_IN && !bus_req
      && pin_rst_n |=> MEM_WRITE_OUT ##1 MEM_WRITE_OUT ##1 !MEM_WRITE_OUT
      && MEM_ADDR_OUT == vec_reg)
      else $error("interrupt entry order wrong");
   manual_bus_a: assert property (in_rst && manual_reg |-> !BUS_UNIT_INIT_OUT)
      else $error("manual reset touched bus unit");
   sleep_run_a: assert property (state_reg == cpspc_pkg::ST_SLEEP
      |-> !PERIPH_HALT_OUT && !CPU_RUN_OUT)
      else $error("sleep halted peripherals");
   one_state_a: assert property (state_reg inside {cpspc_pkg::ST_RESET,
      cpspc_pkg::ST_EXCEPT, cpspc_pkg::ST_BUSREL, cpspc_pkg::ST_EXEC, cpspc_pkg::ST_SLEEP,
      cpspc_pkg::ST_STANDBY})
      else $error("illegal processing state");

   sleep_c: cover property (state_reg == cpspc_pkg::ST_SLEEP ##1
      state_reg == cpspc_pkg::ST_EXCEPT);
   standby_c: cover property (state_reg == cpspc_pkg::ST_STANDBY && stab_reg == 16'h0001);
   busrel_c: cover property (BUS_GRANT_OUT ##1 !BUS_GRANT_OUT);
   manual_c: cover property (in_rst && manual_reg ##1 !in_rst);
   nmi_wake_c: cover property (state_reg == cpspc_pkg::ST_STANDBY && nmi_rise);
endmodule

/* test/cpspc_far_end.sv */
// far-side model: chip reset pin, nmi pin and a bus-requesting master.
// assumes the bench calls its tasks; every pin change lands on a falling edge.
`timescale 1ns/1ps
module cpspc_far_end (
   input wire logic clk_in,
   output logic pin_n_out,
   output logic nmi_out,
   output logic bus_req_out
);
   // ------------------------------------------------------------
   // pin state
   // ------------------------------------------------------------
   initial begin
      pin_n_out = 1'b1;
      nmi_out = 1'b1;
      bus_req_out = 1'b0;
   end

   // ------------------------------------------------------------
   // pin tasks
   // ------------------------------------------------------------
   // nmi level picks the reset kind, so it settles before the pin falls
   task automatic assert_pin(input logic nmi_lvl);
      @(negedge clk_in);
      nmi_out = nmi_lvl;
      @(negedge clk_in);
      pin_n_out = 1'b0;
   endtask

   // caller keeps the pin low through oscillator settling when waking standby
   task automatic release_pin();
      @(negedge clk_in);
      pin_n_out = 1'b1;
   endtask

   task automatic nmi_rise();
      @(negedge clk_in);
      nmi_out = 1'b0;
      @(negedge clk_in);
      nmi_out = 1'b1;
   endtask

   // request stays up for the whole tenure; no cycles driven here at all
   task automatic request_bus(input logic on);
      @(negedge clk_in);
      bus_req_out = on;
   endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the processing-state controller.
// assumes cpspc_map.svh and cpspc_pkg are compiled; assertions live in the design.
`timescale 1ns/1ps
`include "cpspc_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, irq = 1'b0, dma_err = 1'b0, halt = 1'b0;
   logic deep = 1'b0, flt = 1'b0, pin_n, nmi, breq;
   logic grant, run, cinit, pinit, binit, phalt, ostop, pfloat, mreq, mwr, vclr, mload;
   logic [2:0] st;
   logic [31:0] maddr;
   logic [3:0] mask;
   int bad_count = 0, n_compared = 0;

   always #25 clk = ~clk;

   cpspc_far_end far (.clk_in(clk), .pin_n_out(pin_n), .nmi_out(nmi), .bus_req_out(breq));

   cpspc_ctrl DUT (.CLK_IN(clk), .RESET_N_IN(rst_n), .CHIP_INIT_PIN_N_IN(pin_n), .NMI_IN(nmi),
      .IRQ_IN(irq), .DMA_ADDR_ERR_IN(dma_err), .HALT_EXEC_IN(halt),
      .DEEP_HALT_SELECT_IN(deep), .PIN_FLOAT_SELECT_IN(flt), .BUS_REQ_IN(breq),
      .STATE_OUT(st), .BUS_GRANT_OUT(grant), .CPU_RUN_OUT(run), .CPU_INIT_OUT(cinit),
      .PERIPH_INIT_OUT(pinit), .BUS_UNIT_INIT_OUT(binit), .PERIPH_HALT_OUT(phalt),
      .OSC_STOP_OUT(ostop), .PIN_FLOAT_OUT(pfloat), .MEM_REQ_OUT(mreq), .MEM_WRITE_OUT(mwr),
      .MEM_ADDR_OUT(maddr), .VBR_CLEAR_OUT(vclr), .MASK_LOAD_OUT(mload),
      .IRQ_MASK_LEVEL_OUT(mask));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // bounded wait so a stuck state shows up as one mismatch, not a hang
   task automatic wait_st(input cpspc_pkg::cpspc_state_t s, input int lim);
      int i;
      i = 0;
      while (st !== s && i < lim) begin
         @(negedge clk);
         i++;
      end
      `CHK(st, s)
   endtask

   task automatic pulse(ref logic sig);
      @(negedge clk);
      sig = 1'b1;
      @(negedge clk);
      sig = 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic rst_walk(input logic por, input int hold);
      logic [31:0] pc, sp;
      pc = por ? `CPSPC_VEC_POR_PC : `CPSPC_VEC_MAN_PC;
      sp = por ? `CPSPC_VEC_POR_SP : `CPSPC_VEC_MAN_SP;
      far.assert_pin(por);
      repeat (hold) @(negedge clk);
      `CHK(st, 3'(cpspc_pkg::ST_RESET))
      `CHK({cinit, pinit, binit}, {2'b11, por})
      `CHK(mask, 4'h0)
      far.release_pin();
      wait_st(cpspc_pkg::ST_EXCEPT, 6);
      `CHK({mreq, mwr, maddr}, {2'b10, pc})
      @(negedge clk);
      `CHK({mreq, mwr, maddr}, {2'b10, sp})
      // clear and load pulses stand for this one cycle only
      @(negedge clk);
      `CHK({mreq, vclr, mload, mask}, {3'b011, `CPSPC_MASK_ALL})
      wait_st(cpspc_pkg::ST_EXEC, 3);
      `CHK({vclr, mload, mask, run}, {2'b00, `CPSPC_MASK_ALL, 1'b1})
   endtask

   task automatic irq_entry(input logic dma, input logic [31:0] vec);
      if (dma) pulse(dma_err);
      else pulse(irq);
      wait_st(cpspc_pkg::ST_EXCEPT, 4);
      `CHK({mreq, mwr}, 2'b11)
      @(negedge clk);
      `CHK({mreq, mwr}, 2'b11)
      @(negedge clk);
      `CHK({mreq, mwr, maddr}, {2'b10, vec})
      wait_st(cpspc_pkg::ST_EXEC, 3);
   endtask

   task automatic sleep_wake(input logic dma);
      deep = 1'b0;
      pulse(halt);
      wait_st(cpspc_pkg::ST_SLEEP, 3);
      `CHK({phalt, ostop, run}, 3'b000)
      irq_entry(dma, dma ? `CPSPC_VEC_DMAERR : `CPSPC_VEC_NMI);
   endtask

   task automatic bus_release();
      far.request_bus(1'b1);
      wait_st(cpspc_pkg::ST_BUSREL, 5);
      `CHK({grant, run}, 2'b10)
      pulse(halt);
      pulse(irq);
      `CHK(st, 3'(cpspc_pkg::ST_BUSREL))
      far.request_bus(1'b0);
      wait_st(cpspc_pkg::ST_EXEC, 6);
      `CHK(grant, 1'b0)
   endtask

   task automatic standby_enter(input logic fl);
      deep = 1'b1;
      flt = fl;
      pulse(halt);
      wait_st(cpspc_pkg::ST_STANDBY, 3);
      `CHK({phalt, ostop, pinit, pfloat, run}, {3'b111, fl, 1'b0})
      pulse(irq);
      pulse(dma_err);
      `CHK(st, 3'(cpspc_pkg::ST_STANDBY))
   endtask

   task automatic standby_nmi();
      standby_enter(1'b1);
      far.nmi_rise();
      repeat (`CPSPC_OSC_STAB_CYC) @(negedge clk);
      `CHK({st, ostop}, {3'(cpspc_pkg::ST_STANDBY), 1'b0})
      wait_st(cpspc_pkg::ST_EXCEPT, 8);
      wait_st(cpspc_pkg::ST_EXEC, 6);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      wait_st(cpspc_pkg::ST_EXEC, 12);
      rst_walk(1'b1, 4);
      irq_entry(1'b0, `CPSPC_VEC_NMI);
      irq_entry(1'b1, `CPSPC_VEC_DMAERR);
      sleep_wake(1'b1);
      sleep_wake(1'b0);
      bus_release();
      rst_walk(1'b0, 4);
      standby_nmi();
      standby_enter(1'b0);
      rst_walk(1'b1, `CPSPC_OSC_STAB_CYC + 4);
      tally_and_finish();
   end

   // whole run is a few hundred cycles; this span is many times that
   initial begin
      #1000000;
      bad_count++;
      tally_and_finish();
   end
endmodule
